/* File: rtl/see_target.sv */
`default_nettype none
module see_target
    import see_pkg::*;
#(
    parameter int         MEM_KBITS      = MEM_KBITS_DEF,
    parameter int         PROG_CYC       = PROG_CYCLES,
    parameter logic [3:0] TYPE_CODE      = TYPE_CODE_DEF
) (
    input  wire logic       clock,
    input  wire logic       rst,
    see_link_if.dev         link,
    input  wire logic [2:0] select_pins,
    input  wire logic       wp,
    output logic            prog_busy
);
    // ****************************************
    // Size dependent constants
    // ****************************************
    localparam int AW    = $clog2(MEM_KBITS * 128);
    localparam int DEPTH = MEM_KBITS * 128;
    localparam logic [ADDR_W_MAX-1:0] AMASK = ADDR_W_MAX'((1 << AW) - 1);
    localparam bit TWO_ADDR = (MEM_KBITS >= 32);
    localparam logic [2:0] SEL_MASK = (MEM_KBITS == 16) ? 3'h0 :
                                      (MEM_KBITS == 8)  ? 3'h4 : 3'h7;

    if (!(MEM_KBITS == 8 || MEM_KBITS == 16 || MEM_KBITS == 32 || MEM_KBITS == 64)) begin : g_bad
        $error("see_target: MEM_KBITS must be 8, 16, 32 or 64");
    end
    if (PROG_CYC < 2 || PROG_CYC >= (1 << PROG_W)) begin : g_bad_prog
        $error("see_target: PROG_CYC out of range");
    end

    typedef struct packed {
        see_dev_state_t          st;
        see_phase_t              ph;
        logic [3:0]              cnt;
        logic [7:0]              sh;
        logic [ADDR_W_MAX-1:0]   addr;
        logic [7:0]              wdata;
        logic                    wr_pend;
        logic                    rw;
        logic                    rack;
        logic                    sda_oe;
        logic [PROG_W-1:0]       prog;
        logic                    scl_p;
        logic                    sda_p;
    } see_tgt_t;

    see_tgt_t   q;
    see_tgt_t   d;
    logic [5:0] pins_s;
    logic       scl_s;
    logic       sda_s;
    logic [2:0] sel_s;
    logic       wp_s;
    logic       rise;
    logic       fall;
    logic       start_c;
    logic       stop_c;
    logic       match;
    logic       prot;
    logic       mem_we;
    logic [7:0] mem_rd;
    logic [7:0] mem [DEPTH];

    // ****************************************
    // Pin synchronisers
    // ****************************************
    see_sync #(.W(6), .RST_VAL(8'h03)) u_sync (
        .clock (clock),
        .rst   (rst),
        .d     ({select_pins, wp, link.scl, link.sda}),
        .q     (pins_s)
    );
    assign sel_s = pins_s[5:3];
    assign wp_s  = pins_s[2];
    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    assign rise    = scl_s & ~q.scl_p;
    assign fall    = ~scl_s & q.scl_p;
    assign start_c = scl_s & q.scl_p & q.sda_p & ~sda_s;
    assign stop_c  = scl_s & q.scl_p & ~q.sda_p & sda_s;

    assign match = (q.sh[DW_TYPE_HI:DW_TYPE_LO] == TYPE_CODE) &&
                   (((q.sh[DW_SEL_HI:DW_SEL_LO] ^ sel_s) & SEL_MASK) == 3'h0);
    // Live pin level, not latched
    assign prot = wp_s & (TWO_ADDR ? (&q.addr[AW-1:AW-2]) : q.addr[AW-1]);
    assign mem_rd = mem[q.addr[AW-1:0]];

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        d       = q;
        d.scl_p = scl_s;
        d.sda_p = sda_s;
        mem_we  = 1'b0;
        if (q.st == DS_PROG) begin
            // Bus edges are not looked at here
            d.prog = q.prog - PROG_W'(1);
            if (q.prog == PROG_W'(1)) begin
                mem_we    = 1'b1;
                d.addr    = (q.addr + ADDR_W_MAX'(1)) & AMASK;
                d.wr_pend = 1'b0;
                d.st      = DS_IDLE;
            end
        end else if (start_c) begin
            d.st      = DS_RX;
            d.ph      = PH_DEV;
            d.cnt     = 4'h0;
            d.sda_oe  = 1'b0;
            d.wr_pend = 1'b0;
        end else if (stop_c) begin
            d.sda_oe = 1'b0;
            if (q.wr_pend) begin
                d.st   = DS_PROG;
                d.prog = PROG_W'(PROG_CYC);
            end else begin
                d.st = DS_IDLE;
            end
        end else begin
            case (q.st)
                DS_RX: begin
                    if (rise) begin
                        d.sh  = {q.sh[6:0], sda_s};
                        d.cnt = q.cnt + 4'h1;
                    end else if (fall && q.cnt == 4'h8) begin
                        d.st     = DS_ACK;
                        d.sda_oe = 1'b1;
                        case (q.ph)
                            PH_DEV: begin
                                d.rw = q.sh[DW_RW];
                                if (!match) begin
                                    d.st     = DS_IDLE;
                                    d.sda_oe = 1'b0;
                                end else if (!q.sh[DW_RW]) begin
                                    if (MEM_KBITS == 8) begin
                                        d.addr[9:8] = q.sh[2:1];
                                    end else if (MEM_KBITS == 16) begin
                                        d.addr[10:8] = q.sh[3:1];
                                    end
                                    d.ph = TWO_ADDR ? PH_AH : PH_AL;
                                end
                            end
                            PH_AH: begin
                                d.addr = {q.sh[4:0], q.addr[7:0]} & AMASK;
                                d.ph   = PH_AL;
                            end
                            PH_AL: begin
                                d.addr[7:0] = q.sh;
                                d.ph        = PH_DATA;
                            end
                            PH_DATA: begin
                                // Later bytes replace earlier ones
                                d.wdata   = q.sh;
                                d.wr_pend = ~prot;
                            end
                            default: d.st = DS_IDLE;
                        endcase
                    end
                end
                DS_ACK: begin
                    if (fall) begin
                        d.sda_oe = 1'b0;
                        d.cnt    = 4'h0;
                        if (q.rw) begin
                            d.st     = DS_TX;
                            d.sh     = mem_rd;
                            d.addr   = (q.addr + ADDR_W_MAX'(1)) & AMASK;
                            d.sda_oe = ~mem_rd[7];
                        end else begin
                            d.st = DS_RX;
                        end
                    end
                end
                DS_TX: begin
                    if (fall) begin
                        if (q.cnt == 4'h7) begin
                            d.st     = DS_RACK;
                            d.sda_oe = 1'b0;
                            d.rack   = 1'b1;
                        end else begin
                            d.sh     = {q.sh[6:0], 1'b0};
                            d.cnt    = q.cnt + 4'h1;
                            d.sda_oe = ~q.sh[6];
                        end
                    end
                end
                DS_RACK: begin
                    if (rise) begin
                        d.rack = sda_s;
                    end else if (fall) begin
                        if (!q.rack) begin
                            d.st     = DS_TX;
                            d.cnt    = 4'h0;
                            d.sh     = mem_rd;
                            d.addr   = (q.addr + ADDR_W_MAX'(1)) & AMASK;
                            d.sda_oe = ~mem_rd[7];
                        end else begin
                            d.st = DS_WAIT;
                        end
                    end
                end
                DS_IDLE, DS_WAIT: d.sda_oe = 1'b0;
                default: begin
                    d.st     = DS_IDLE;
                    d.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // Registers and array
    // ****************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q <= '{st: DS_IDLE, ph: PH_DEV, rack: 1'b1, scl_p: 1'b1, sda_p: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end

    // Array has no reset, as a real cell array
    always_ff @(posedge clock) begin
        if (mem_we) begin
            mem[q.addr[AW-1:0]] <= q.wdata;
        end
    end

    assign link.dev_sda_o  = 1'b0;
    assign link.dev_sda_oe = q.sda_oe;
    assign prog_busy       = (q.st == DS_PROG);
endmodule
`default_nettype wire

/* File: rtl/see_pkg.sv */
`default_nettype none
package see_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS  = 50;
    localparam int SCL_MAX_KHZ    = 400;
    localparam int SCL_MIN_PER_NS = 1000000 / SCL_MAX_KHZ;
    // Least time, so round up
    localparam int SCL_QTR_CYCLES = (SCL_MIN_PER_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
    localparam int INTERNAL_PROGRAM_TIME_MS = 10;
    // Longest time, so round down
    localparam int PROG_CYCLES    = INTERNAL_PROGRAM_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int PROG_W         = 24;
    localparam int QTR_W          = 8;

    // ****************************************
    // Address word layout
    // ****************************************
    localparam int ADDR_W_MAX     = 13;
    localparam int DW_TYPE_HI     = 7;
    localparam int DW_TYPE_LO     = 4;
    localparam int DW_SEL_HI      = 3;
    localparam int DW_SEL_LO      = 1;
    localparam int DW_RW          = 0;
    // Arbitrary neutral type code
    localparam logic [3:0] TYPE_CODE_DEF = 4'h5;
    localparam int MEM_KBITS_DEF  = 64;

    // ****************************************
    // State encodings
    // ****************************************
    typedef enum logic [6:0] {
        DS_IDLE = 7'h01,
        DS_RX   = 7'h02,
        DS_ACK  = 7'h04,
        DS_TX   = 7'h08,
        DS_RACK = 7'h10,
        DS_WAIT = 7'h20,
        DS_PROG = 7'h40
    } see_dev_state_t;

    typedef enum logic [3:0] {
        PH_DEV  = 4'h1,
        PH_AH   = 4'h2,
        PH_AL   = 4'h4,
        PH_DATA = 4'h8
    } see_phase_t;

    typedef enum logic [3:0] {
        HS_IDLE  = 4'h1,
        HS_START = 4'h2,
        HS_BITS  = 4'h4,
        HS_STOP  = 4'h8
    } see_host_state_t;

endpackage
`default_nettype wire

/* File: rtl/see_link_if.sv */
`default_nettype none
interface see_link_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic sda;

    // Open-drain wire with pull-up
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
    modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface
`default_nettype wire

/* File: rtl/see_sync.sv */
`default_nettype none
module see_sync #(
    parameter int         W       = 1,
    parameter logic [7:0] RST_VAL = 8'hff
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    if (W > 8) begin : g_bad
        $error("see_sync: W above 8");
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_q <= RST_VAL[W-1:0];
            q      <= RST_VAL[W-1:0];
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/see_ctrl.sv */
`default_nettype none
module see_ctrl
    import see_pkg::*;
#(
    parameter bit         TWO_ADDR  = 1'b1,
    parameter int         QTR       = SCL_QTR_CYCLES,
    parameter logic [3:0] TYPE_CODE = TYPE_CODE_DEF
) (
    input  wire logic        clock,
    input  wire logic        rst,
    see_link_if.host         link,
    input  wire logic        req,
    input  wire logic        req_read,
    input  wire logic [2:0]  sel,
    input  wire logic [15:0] mem_addr,
    input  wire logic [7:0]  wdata,
    output logic             busy,
    output logic             done,
    output logic             nack,
    output logic [7:0]       rdata
);
    // Quarter length keeps the clock at or below the top rate
    if (QTR < SCL_QTR_CYCLES || QTR >= (1 << QTR_W)) begin : g_bad
        $error("see_ctrl: QTR too fast or too large");
    end

    typedef struct packed {
        see_host_state_t st;
        logic [QTR_W-1:0] div;
        logic [1:0]       qi;
        logic [3:0]       bitn;
        logic [1:0]       byten;
        logic [8:0]       so;
        logic [8:0]       si;
        logic             scl;
        logic             sda_oe;
        logic             rd;
        logic [2:0]       sel;
        logic [15:0]      addr;
        logic [7:0]       wdata;
        logic             done;
        logic             nack;
        logic [7:0]       rdata;
    } see_ctl_t;

    see_ctl_t   q;
    see_ctl_t   d;
    logic       sda_s;
    logic       tick;
    logic [1:0] last_byte;

    see_sync #(.W(1), .RST_VAL(8'h01)) u_sync (
        .clock (clock),
        .rst   (rst),
        .d     (link.sda),
        .q     (sda_s)
    );

    assign tick      = (q.div == QTR_W'(QTR - 1));
    assign last_byte = q.rd ? 2'd1 : (TWO_ADDR ? 2'd3 : 2'd2);

    // Slot word: byte then released acknowledge slot
    function automatic logic [8:0] slot(input logic [1:0] n, input logic rd_f,
                                        input logic [2:0] s, input logic [15:0] a,
                                        input logic [7:0] w);
        logic [7:0] b;
        b = 8'hff;
        if (n == 2'd0) begin
            b = {TYPE_CODE, s, rd_f};
        end else if (!rd_f) begin
            if (TWO_ADDR) begin
                b = (n == 2'd1) ? a[15:8] : (n == 2'd2) ? a[7:0] : w;
            end else begin
                b = (n == 2'd1) ? a[7:0] : w;
            end
        end
        return {b, 1'b1};
    endfunction

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        d      = q;
        d.done = 1'b0;
        if (q.st == HS_IDLE) begin
            d.scl    = 1'b1;
            d.sda_oe = 1'b0;
            d.div    = '0;
            d.qi     = 2'd0;
            if (req) begin
                d.st    = HS_START;
                d.rd    = req_read;
                d.sel   = sel;
                d.addr  = mem_addr;
                d.wdata = wdata;
                d.nack  = 1'b0;
            end
        end else if (!tick) begin
            d.div = q.div + QTR_W'(1);
        end else begin
            d.div = '0;
            d.qi  = q.qi + 2'd1;
            case (q.st)
                HS_START: begin
                    if (q.qi == 2'd0) d.sda_oe = 1'b1;
                    if (q.qi == 2'd2) d.scl = 1'b0;
                    if (q.qi == 2'd3) begin
                        d.st    = HS_BITS;
                        d.byten = 2'd0;
                        d.bitn  = 4'h0;
                        d.so    = slot(2'd0, q.rd, q.sel, q.addr, q.wdata);
                    end
                end
                HS_BITS: begin
                    case (q.qi)
                        2'd0: d.sda_oe = ~q.so[8];
                        2'd1: d.scl = 1'b1;
                        2'd2: d.si = {q.si[7:0], sda_s};
                        default: begin
                            d.scl = 1'b0;
                            d.so  = {q.so[7:0], 1'b1};
                            d.bitn = q.bitn + 4'h1;
                            if (q.bitn == 4'h8) begin
                                d.bitn = 4'h0;
                                if (!(q.rd && q.byten == 2'd1) && q.si[0]) begin
                                    d.nack = 1'b1;
                                    d.st   = HS_STOP;
                                end else if (q.byten == last_byte) begin
                                    if (q.rd) d.rdata = q.si[8:1];
                                    d.st = HS_STOP;
                                end else begin
                                    d.byten = q.byten + 2'd1;
                                    d.so    = slot(q.byten + 2'd1, q.rd, q.sel, q.addr, q.wdata);
                                end
                            end
                        end
                    endcase
                end
                HS_STOP: begin
                    case (q.qi)
                        2'd0: d.sda_oe = 1'b1;
                        2'd1: d.scl = 1'b1;
                        2'd2: d.sda_oe = 1'b0;
                        default: begin
                            d.st   = HS_IDLE;
                            d.done = 1'b1;
                        end
                    endcase
                end
                default: d.st = HS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q <= '{st: HS_IDLE, scl: 1'b1, so: 9'h1ff, default: '0};
        end else begin
            q <= d;
        end
    end

    assign link.scl         = q.scl;
    assign link.host_sda_o  = 1'b0;
    assign link.host_sda_oe = q.sda_oe;
    assign busy             = (q.st != HS_IDLE);
    assign done             = q.done;
    assign nack             = q.nack;
    assign rdata            = q.rdata;
endmodule
`default_nettype wire

/* File: bench/see_link_sva.sv */
`default_nettype none
module see_link_sva
    import see_pkg::*;
#(
    parameter logic [3:0] TYPE_CODE = TYPE_CODE_DEF
) (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       scl,
    input wire logic       sda,
    input wire logic       dev_sda_o,
    input wire logic       dev_sda_oe,
    input wire logic [2:0] select_pins
);
    // ****************
    // Bus tracking
    // ****************
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic [2:0] fall_q;
    logic       scl_q, sda_q, first_q, rw_q, sel_q, nak_q, rise;
    assign rise = scl & ~scl_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            {scl_q, sda_q, fall_q} <= 5'h1f;
            {cnt_q, sh_q, first_q, rw_q, sel_q, nak_q} <= '0;
        end else begin
            scl_q  <= scl;
            sda_q  <= sda;
            // Saturates, so a change long after a fall still fails
            fall_q <= (scl_q & ~scl) ? 3'h0 : fall_q + {2'h0, fall_q != 3'h7};
            if (scl & scl_q & (sda != sda_q)) begin
                cnt_q   <= '0;
                first_q <= ~sda;
                sel_q   <= 1'b0;
                nak_q   <= 1'b0;
            end else if (rise) begin
                sh_q  <= {sh_q[6:0], sda};
                cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
                if (first_q && cnt_q == 4'h7)
                    rw_q <= sda;
                if (cnt_q == 4'h8) begin
                    first_q <= 1'b0;
                    sel_q   <= first_q ? ~sda : sel_q;
                    nak_q   <= ~first_q & rw_q & sda;
                end
            end
        end
    end
    // ****************
    // Checks
    // ****************
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence start_s;
        scl && scl_q && $fell(sda);
    endsequence
    sequence stop_s;
        scl && scl_q && $rose(sda);
    endsequence
    sequence ack_s;
        rise && cnt_q == 4'h8;
    endsequence
    od_drive_a: assert property (dev_sda_oe |-> !dev_sda_o)
        else $error("target drove data high");
    low_change_a: assert property ($changed(dev_sda_oe) |-> !scl && !scl_q)
        else $error("target data changed with clock high");
    after_fall_a: assert property ($changed(dev_sda_oe) |-> fall_q inside {[1:6]})
        else $error("target data not launched after clock fall");
    slot_only_a: assert property (rise && dev_sda_oe && (first_q || !rw_q) |-> cnt_q == 4'h8)
        else $error("target pulled data outside ack slot");
    write_ack_a: assert property (ack_s ##0 (!first_q && sel_q && !rw_q) |-> dev_sda_oe)
        else $error("written word not acknowledged");
    read_free_a: assert property (ack_s ##0 (!first_q && rw_q) |-> !dev_sda_oe)
        else $error("target held data in read ack slot");
    no_resend_a: assert property (nak_q |-> !dev_sda_oe)
        else $error("target sent data after no-ack");
    sel_miss_a: assert property (ack_s ##0 (first_q && (sh_q[7:4] != TYPE_CODE
        || sh_q[3:1] != select_pins)) |-> !dev_sda_oe) else $error("mismatch acknowledged");
    start_free_a: assert property (start_s |-> !dev_sda_oe)
        else $error("target driving at start");
    stop_idle_a: assert property (stop_s |=> !dev_sda_oe [*4])
        else $error("target driving after stop");
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`default_nettype none
module tb_top
    import see_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // Long enough to overlap a whole address word
    localparam int PROG = 800;
    typedef struct packed {logic nack; logic rd; logic [7:0] data;} see_exp_t;
    logic        clock, rst, req, req_read, wp, busy, done, nack, prog_busy;
    logic [2:0]  sel, pins;
    logic [15:0] mem_addr, a;
    logic [7:0]  wdata, rdata, d1;
    logic [31:0] lfsr_q;
    int          n_mismatch = 0, num_checks = 0, cyc = 0, plen = 0;
    see_exp_t    exp_q[$];
    see_exp_t    ex;

    see_link_if i_see_link_if ();
    see_target #(.MEM_KBITS(64), .PROG_CYC(PROG)) i_see_target (.clock(clock), .rst(rst),
        .link(i_see_link_if.dev), .select_pins(pins), .wp(wp), .prog_busy(prog_busy));
    see_ctrl #(.TWO_ADDR(1'b1)) i_see_ctrl (.clock(clock), .rst(rst),
        .link(i_see_link_if.host), .req(req), .req_read(req_read), .sel(sel),
        .mem_addr(mem_addr), .wdata(wdata), .busy(busy), .done(done), .nack(nack),
        .rdata(rdata));
    see_link_sva i_sva (.clock(clock), .rst(rst), .scl(i_see_link_if.scl),
        .sda(i_see_link_if.sda), .dev_sda_o(i_see_link_if.dev_sda_o),
        .dev_sda_oe(i_see_link_if.dev_sda_oe), .select_pins(pins));

    // ****************
    // Helpers
    // ****************
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] expd);
        num_checks++;
        if (seen !== expd) begin
            n_mismatch++;
            $display("[ERR] %s exp %h seen %h", nm, expd, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic op(input logic rd, input logic [2:0] s, input logic [15:0] ad,
                      input logic [7:0] d, input logic nk);
        int t;
        @(posedge clock);
        req      <= 1'b1;
        req_read <= rd;
        sel      <= s;
        mem_addr <= ad;
        wdata    <= d;
        exp_q.push_back('{nk, rd, d});
        @(posedge clock);
        req <= 1'b0;
        t = 0;
        @(posedge clock);
        chk("busy", 16'(busy), 16'h1);
        while (done !== 1'b1 && t < 4000) begin
            @(posedge clock);
            t++;
        end
        if (t >= 4000)
            n_mismatch++;
        chk("busy", 16'(busy), 16'h0);
        repeat (2) @(posedge clock);
    endtask
    task automatic idle();
        int t;
        t = 0;
        while (prog_busy !== 1'b0 && t < 2000) begin
            @(posedge clock);
            t++;
        end
        if (t >= 2000)
            n_mismatch++;
    endtask

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            close_out();
        end
    end
    always @(posedge clock) begin
        if (done === 1'b1) begin
            ex = exp_q.pop_front();
            chk("nack", 16'(nack), 16'(ex.nack));
            if (ex.rd)
                chk("rdata", 16'(rdata), 16'(ex.data));
        end
    end
    always @(posedge clock) begin
        if (prog_busy === 1'b1) begin
            plen <= plen + 1;
        end else begin
            if (plen != 0)
                chk("prog_len", plen[15:0], 16'(PROG));
            plen <= 0;
        end
    end

    // ****************
    // Scenarios
    // ****************
    initial begin
        {rst, req, req_read, wp, sel, pins, mem_addr, wdata} = {4'h8, 3'h5, 3'h5, 24'h0};
        lfsr_q = 32'h995d;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        lfsr_q = lfsr(lfsr_q);
        a      = lfsr_q[15:0] % 16'h17fe;
        lfsr_q = lfsr(lfsr_q);
        d1     = lfsr_q[7:0];
        op(1'b0, pins, a + 16'h1, d1, 1'b0);
        chk("prog_busy", 16'(prog_busy), 16'h1);
        op(1'b0, pins, a, ~d1, 1'b1);
        idle();
        op(1'b0, pins, a, ~d1, 1'b0);
        idle();
        op(1'b1, pins, 16'h0, d1, 1'b0);
        op(1'b0, pins ^ 3'h2, a, d1, 1'b1);
        chk("prog_busy", 16'(prog_busy), 16'h0);
        wp <= 1'b1;
        op(1'b0, pins, 16'h1800, d1, 1'b0);
        chk("prog_busy", 16'(prog_busy), 16'h0);
        op(1'b0, pins, 16'h17ff, d1, 1'b0);
        chk("prog_busy", 16'(prog_busy), 16'h1);
        idle();
        close_out();
    end
endmodule
`default_nettype wire
